// File: design/ata_cmd_engine.sv
/*
 * Task-file command engine for Idle Immediate, Initialize Device
 * Parameters, NOP and Read Buffer, with the automatic power-down timer.
 * Assumes host accesses arrive synchronous to clk, one per cycle, and
 * that another block fills the sector buffer on Write Buffer.
 */
`timescale 1ns/1ps

// Contract
// - Idle Immediate, under either opcode, enters performance idle.
// - Spin-up is started only when the spindle is stopped.
// - In idle the spindle keeps turning and commands are taken at once.
// - Idle Immediate leaves the power-down timeout and its enable alone.
// - Initialize Parameters stores sector count and low four head bits.
// - Stored geometry is presented for the identify data words.
// - Geometry lasts until reinit, power loss, reset or revert option.
// - Zero sectors per track means zero, never 256.
// - NOP always aborts with error and command-aborted flagged.
// - NOP subcode zero flushes the queue; nonzero leaves it.
// - NOP leaves the address registers as the host wrote them.
// - Read Buffer sends exactly one sector to the host.
// - The sector passes as 16-bit words through the data register.
// - Read Buffer reads the region last filled by Write Buffer.
// - Power-down timer sends the device to standby; access restarts it.
module ata_cmd_engine (
    input  wire logic                         clk,            // 100 MHz clock
    input  wire logic                         rst_b,          // Hard reset, async
    input  wire logic                         soft_rst,       // Soft reset pulse
    input  wire ata_cmd_pkg::tf_req_t         tf_req,         // Host register access
    output logic [15:0]                       tf_rdata_r,     // Read data, next cycle
    output logic                              intrq_r,        // Host interrupt level
    input  wire logic                         spindle_rot,    // Spindle at speed
    input  wire logic                         index_mark,     // Index sensor
    output logic                              spin_up_r,      // Spin-up request
    output logic                              standby_r,      // Standby power state
    input  wire logic                         apd_en,         // Power-down enabled
    input  wire logic [31:0]                  apd_limit,      // Timeout in cycles
    input  wire logic                         revert_set,     // Revert option set
    output ata_cmd_pkg::geom_t                geom_r,         // Identify geometry
    output logic                              queue_abort_r,  // Queue flush pulse
    input  wire logic                         wbuf_we,        // Buffer fill strobe
    input  wire logic [ata_cmd_pkg::BUF_AW-1:0] wbuf_addr,    // Buffer fill address
    input  wire logic [15:0]                  wbuf_data       // Buffer fill word
);

    // ************************************************************
    // Declarations
    // ************************************************************
    ata_cmd_pkg::cmd_state_t            state_r, state_nxt;
    logic [7:0]                         feat_r, scnt_r, snum_r;
    logic [7:0]                         cyllo_r, cylhi_r, devhd_r;
    logic [7:0]                         cmd_r;
    logic                               bsy_r, drq_r, err_r, abt_r;
    logic [ata_cmd_pkg::BUF_AW-1:0]     ptr_r;
    logic [31:0]                        apd_cnt_r;
    logic [15:0]                        sect_buf [ata_cmd_pkg::BUF_WORDS];

    // ************************************************************
    // Access decode
    // ************************************************************
    wire wr_cmd    = tf_req.wr && tf_req.addr == ata_cmd_pkg::A_CMD;
    wire wr_reg    = tf_req.wr && !bsy_r;
    wire rd_stat   = tf_req.rd && tf_req.addr == ata_cmd_pkg::A_CMD;
    wire rd_data   = tf_req.rd && tf_req.addr == ata_cmd_pkg::A_DATA;
    wire take_cmd  = wr_cmd && !bsy_r && !drq_r;
    wire host_acc  = tf_req.wr || tf_req.rd;
    wire is_idle   = cmd_r == ata_cmd_pkg::OP_IDLE_IMM
                  || cmd_r == ata_cmd_pkg::OP_IDLE_IMM_2;
    wire is_init   = cmd_r == ata_cmd_pkg::OP_INIT_PARMS;
    wire is_nop    = cmd_r == ata_cmd_pkg::OP_NOP;
    wire is_rdbuf  = cmd_r == ata_cmd_pkg::OP_READ_BUF;
    wire in_exec   = state_r == ata_cmd_pkg::ST_EXEC;
    wire in_spin   = state_r == ata_cmd_pkg::ST_SPIN;
    wire in_xfer   = state_r == ata_cmd_pkg::ST_XFER;
    wire xfer_pop  = in_xfer && rd_data;
    wire xfer_last = xfer_pop && ptr_r == ata_cmd_pkg::PTR_LAST;
    wire spin_done = in_spin && spindle_rot;
    wire do_abort  = in_exec && !is_idle && !is_init && !is_rdbuf;
    wire finish    = (in_exec && !is_rdbuf && !(is_idle && !spindle_rot))
                  || spin_done || xfer_last;
    wire apd_hit   = apd_en && !standby_r && apd_cnt_r >= apd_limit;

    wire [7:0] status_w = {bsy_r, !standby_r, 1'b0, spindle_rot,
                           drq_r, 1'b0, index_mark, err_r};
    wire [7:0] error_w  = {5'h00, abt_r, 2'h0};

    // ************************************************************
    // Command sequencer
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ata_cmd_pkg::ST_READY: begin
                if (take_cmd) begin
                    state_nxt = ata_cmd_pkg::ST_EXEC;
                end
            end
            ata_cmd_pkg::ST_EXEC: begin
                if (is_idle && !spindle_rot) begin
                    state_nxt = ata_cmd_pkg::ST_SPIN;
                end else if (is_rdbuf) begin
                    state_nxt = ata_cmd_pkg::ST_XFER;
                end else begin
                    state_nxt = ata_cmd_pkg::ST_READY;
                end
            end
            ata_cmd_pkg::ST_SPIN: begin
                if (spindle_rot) begin
                    state_nxt = ata_cmd_pkg::ST_READY;
                end
            end
            ata_cmd_pkg::ST_XFER: begin
                if (xfer_last) begin
                    state_nxt = ata_cmd_pkg::ST_READY;
                end
            end
            default: begin
                state_nxt = ata_cmd_pkg::ST_READY;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ata_cmd_pkg::ST_READY;
        end else if (soft_rst) begin
            state_r <= ata_cmd_pkg::ST_READY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Host-written command block registers
    // ************************************************************
    // Only host writes change these, so NOP leaves them intact.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            feat_r  <= ata_cmd_pkg::REG_RST;
            scnt_r  <= ata_cmd_pkg::REG_RST;
            snum_r  <= ata_cmd_pkg::REG_RST;
            cyllo_r <= ata_cmd_pkg::REG_RST;
            cylhi_r <= ata_cmd_pkg::REG_RST;
            devhd_r <= ata_cmd_pkg::DEVHD_RST;
            cmd_r   <= ata_cmd_pkg::REG_RST;
        end else if (wr_reg) begin
            case (tf_req.addr)
                ata_cmd_pkg::A_FEAT:  feat_r  <= tf_req.wdata[7:0];
                ata_cmd_pkg::A_SCNT:  scnt_r  <= tf_req.wdata[7:0];
                ata_cmd_pkg::A_SNUM:  snum_r  <= tf_req.wdata[7:0];
                ata_cmd_pkg::A_CYLLO: cyllo_r <= tf_req.wdata[7:0];
                ata_cmd_pkg::A_CYLHI: cylhi_r <= tf_req.wdata[7:0];
                ata_cmd_pkg::A_DEVHD: devhd_r <= tf_req.wdata[7:0];
                ata_cmd_pkg::A_CMD:   cmd_r   <= tf_req.wdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Status, error and interrupt
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bsy_r <= 1'b0;
            drq_r <= 1'b0;
            err_r <= 1'b0;
            abt_r <= 1'b0;
        end else if (soft_rst) begin
            bsy_r <= 1'b0;
            drq_r <= 1'b0;
            err_r <= 1'b0;
            abt_r <= 1'b0;
        end else if (take_cmd) begin
            bsy_r <= 1'b1;
            err_r <= 1'b0;
            abt_r <= 1'b0;
        end else begin
            if (finish) begin
                bsy_r <= 1'b0;
            end
            if (in_exec && is_rdbuf) begin
                bsy_r <= 1'b0;
                drq_r <= 1'b1;
            end
            if (xfer_last) begin
                drq_r <= 1'b0;
            end
            if (do_abort) begin
                err_r <= 1'b1;
                abt_r <= 1'b1;
            end
        end
    end

    // The completion wins over a status read in the same cycle, so no
    // interrupt is lost when the host polls just as a command ends.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            intrq_r <= 1'b0;
        end else if (finish) begin
            intrq_r <= 1'b1;
        end else if (rd_stat || take_cmd || soft_rst) begin
            intrq_r <= 1'b0;
        end
    end

    // ************************************************************
    // Queue flush
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            queue_abort_r <= 1'b0;
        end else begin
            queue_abort_r <= in_exec && is_nop
                          && feat_r == ata_cmd_pkg::REG_RST;
        end
    end

    // ************************************************************
    // Geometry
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            geom_r <= '{spt: ata_cmd_pkg::SPT_RST, heads_m1: ata_cmd_pkg::HEADS_RST};
        end else if (soft_rst || revert_set) begin
            geom_r <= '{spt: ata_cmd_pkg::SPT_RST, heads_m1: ata_cmd_pkg::HEADS_RST};
        end else if (in_exec && is_init) begin
            // Zero is kept as zero; nothing maps it to 256.
            geom_r.spt      <= scnt_r;
            geom_r.heads_m1 <= devhd_r[ata_cmd_pkg::HEAD_W-1:0];
        end
    end

    // ************************************************************
    // Power state and spindle
    // ************************************************************
    // The timeout and its enable are inputs owned by the Idle command
    // logic; nothing here writes them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            standby_r <= 1'b0;
            spin_up_r <= 1'b0;
        end else begin
            if (in_exec && is_idle) begin
                standby_r <= 1'b0;
                spin_up_r <= !spindle_rot;
            end else if (apd_hit) begin
                standby_r <= 1'b1;
            end
            if (spin_done) begin
                spin_up_r <= 1'b0;
            end
        end
    end

    // Counting stops in standby; any host access restarts the interval.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            apd_cnt_r <= '0;
        end else if (host_acc || !apd_en || standby_r) begin
            apd_cnt_r <= '0;
        end else if (!apd_hit) begin
            apd_cnt_r <= apd_cnt_r + ata_cmd_pkg::APD_ONE;
        end
    end

    // ************************************************************
    // Sector buffer and data port
    // ************************************************************
    always_ff @(posedge clk) begin
        if (wbuf_we) begin
            sect_buf[wbuf_addr] <= wbuf_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_r <= '0;
        end else if (take_cmd || soft_rst) begin
            ptr_r <= '0;
        end else if (xfer_pop) begin
            ptr_r <= ptr_r + 1'b1;
        end
    end

    // Reads are answered one cycle later; a data read outside a transfer
    // returns zero and does not advance the pointer.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tf_rdata_r <= '0;
        end else if (tf_req.rd) begin
            case (tf_req.addr)
                ata_cmd_pkg::A_DATA:  tf_rdata_r <= in_xfer ? sect_buf[ptr_r] : '0;
                ata_cmd_pkg::A_FEAT:  tf_rdata_r <= {8'h00, error_w};
                ata_cmd_pkg::A_SCNT:  tf_rdata_r <= {8'h00, scnt_r};
                ata_cmd_pkg::A_SNUM:  tf_rdata_r <= {8'h00, snum_r};
                ata_cmd_pkg::A_CYLLO: tf_rdata_r <= {8'h00, cyllo_r};
                ata_cmd_pkg::A_CYLHI: tf_rdata_r <= {8'h00, cylhi_r};
                ata_cmd_pkg::A_DEVHD: tf_rdata_r <= {8'h00, devhd_r};
                default:              tf_rdata_r <= {8'h00, status_w};
            endcase
        end
    end

endmodule : ata_cmd_engine

// File: inc/ata_cmd_pkg.sv
/*
 * Constants and carrier types for the task-file command engine.
 * Assumes a host controller that addresses the eight command-block
 * registers by a three-bit index, one access per clock.
 */
package ata_cmd_pkg;
    // Command-block register indices.
    localparam logic [2:0] A_DATA   = 3'h0;
    localparam logic [2:0] A_FEAT   = 3'h1;  // Write: feature, read: error.
    localparam logic [2:0] A_SCNT   = 3'h2;
    localparam logic [2:0] A_SNUM   = 3'h3;
    localparam logic [2:0] A_CYLLO  = 3'h4;
    localparam logic [2:0] A_CYLHI  = 3'h5;
    localparam logic [2:0] A_DEVHD  = 3'h6;
    localparam logic [2:0] A_CMD    = 3'h7;  // Write: command, read: status.

    // Opcodes.
    localparam logic [7:0] OP_IDLE_IMM   = 8'he1;
    localparam logic [7:0] OP_IDLE_IMM_2 = 8'h95;
    localparam logic [7:0] OP_INIT_PARMS = 8'h91;
    localparam logic [7:0] OP_NOP        = 8'h00;
    localparam logic [7:0] OP_READ_BUF   = 8'he4;

    // Status bit positions.
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DF  = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_COR = 2;
    localparam int ST_IDX = 1;
    localparam int ST_ERR = 0;
    // Error bit position.
    localparam int ER_ABT = 2;

    // Field layouts and sizes.
    localparam int HEAD_W    = 4;
    localparam int BUF_WORDS = 256;
    localparam int BUF_AW    = 8;
    localparam logic [7:0]        SPT_RST   = 8'h00;
    localparam logic [HEAD_W-1:0] HEADS_RST = 4'h0;
    localparam logic [7:0]        REG_RST   = 8'h00;
    localparam logic [7:0]        DEVHD_RST = 8'ha0;
    localparam logic [BUF_AW-1:0] PTR_LAST  = 8'hff;
    localparam logic [31:0]       APD_ONE   = 32'h0000_0001;

    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_EXEC  = 4'b0010,
        ST_SPIN  = 4'b0100,
        ST_XFER  = 4'b1000
    } cmd_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } tf_req_t;

    typedef struct packed {
        logic [7:0]        spt;
        logic [HEAD_W-1:0] heads_m1;
    } geom_t;
endpackage : ata_cmd_pkg

// File: sim/ata_cmd_props.sv
/* Concurrent checks on the task-file command engine, bound to its ports.
   Assumes the host issues a command only once the previous one has ended. */
`timescale 1ns/1ps
module ata_cmd_props (
    input wire logic                             clk,           // Clock
    input wire logic                             rst_b,         // Hard reset
    input wire logic                             soft_rst,      // Soft reset
    input wire ata_cmd_pkg::tf_req_t             tf_req,        // Host access
    input wire logic [15:0]                      tf_rdata_r,    // Read data
    input wire logic                             intrq_r,       // Interrupt
    input wire logic                             spindle_rot,   // Spindle at speed
    input wire logic                             index_mark,    // Index sensor
    input wire logic                             spin_up_r,     // Spin-up request
    input wire logic                             standby_r,     // Standby state
    input wire logic                             apd_en,        // Power-down enable
    input wire logic [31:0]                      apd_limit,     // Timeout
    input wire logic                             revert_set,    // Revert option
    input wire ata_cmd_pkg::geom_t               geom_r,        // Geometry
    input wire logic                             queue_abort_r, // Queue flush
    input wire logic                             wbuf_we,       // Buffer fill strobe
    input wire logic [ata_cmd_pkg::BUF_AW-1:0]   wbuf_addr,     // Buffer fill address
    input wire logic [15:0]                      wbuf_data      // Buffer fill word
);
    // ****************************************
    // Shadow of the host's register writes.
    // ****************************************
    logic [7:0] tf_r [8];
    logic [8:0] rdcnt_r;
    logic [8:0] rdcnt_nxt;
    wire logic [7:0] op      = tf_req.wdata[7:0];
    wire logic       cmd_wr  = tf_req.wr && tf_req.addr == ata_cmd_pkg::A_CMD;
    wire logic       idle_wr = cmd_wr && (op == ata_cmd_pkg::OP_IDLE_IMM || op == ata_cmd_pkg::OP_IDLE_IMM_2);
    wire logic       init_wr = cmd_wr && op == ata_cmd_pkg::OP_INIT_PARMS;
    wire logic       dat_rd  = tf_req.rd && tf_req.addr == ata_cmd_pkg::A_DATA;
    assign rdcnt_nxt = (cmd_wr && op == ata_cmd_pkg::OP_READ_BUF) ? 9'h000 : rdcnt_r + {8'h00, dat_rd};
    always_ff @(posedge clk) begin
        if (tf_req.wr) begin
            tf_r[tf_req.addr] <= tf_req.wdata[7:0];
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdcnt_r <= 9'h000;
        end else begin
            rdcnt_r <= rdcnt_nxt;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    AST_IDLE_DONE: assert property (idle_wr && spindle_rot |-> ##2 intrq_r && !standby_r && !spin_up_r)
        else $error("idle immediate did not end in idle");
    AST_SPIN_START: assert property (idle_wr && !spindle_rot |-> ##2 spin_up_r)
        else $error("spin-up missing with spindle stopped");
    AST_SPIN_CAUSE: assert property ($rose(spin_up_r) |-> !$past(spindle_rot))
        else $error("spin-up raised with spindle turning");
    AST_NOP_ABORT: assert property (cmd_wr && op == 8'h00 |-> ##2 intrq_r && queue_abort_r == (tf_r[1] == 8'h00))
        else $error("nop ending or queue flush wrong");
    AST_FLUSH_PULSE: assert property (queue_abort_r |=> !queue_abort_r)
        else $error("queue flush longer than one cycle");
    AST_GEOM_SET: assert property (init_wr |-> ##2 geom_r == {tf_r[2], tf_r[6][3:0]})
        else $error("geometry not taken from task file");
    AST_GEOM_HOLD: assert property (!$stable(geom_r) |-> $past(init_wr, 2) || $past(soft_rst) || $past(revert_set))
        else $error("geometry changed without cause");
    AST_RBUF_END: assert property (dat_rd && rdcnt_r == 9'd255 |=> intrq_r)
        else $error("no interrupt after last buffer word");
    AST_STBY_CAUSE: assert property ($rose(standby_r) |-> $past(apd_en))
        else $error("standby entered with power-down off");
    cover property (cmd_wr && op == 8'h00 && tf_r[1] == 8'h00);
    cover property ($rose(spin_up_r));
    cover property ($rose(standby_r));
    cover property (dat_rd && rdcnt_r == 9'd255);
endmodule : ata_cmd_props
bind ata_cmd_engine ata_cmd_props i_ata_cmd_props (
    .clk(clk), .rst_b(rst_b), .soft_rst(soft_rst), .tf_req(tf_req), .tf_rdata_r(tf_rdata_r),
    .intrq_r(intrq_r), .spindle_rot(spindle_rot), .index_mark(index_mark), .spin_up_r(spin_up_r),
    .standby_r(standby_r), .apd_en(apd_en), .apd_limit(apd_limit), .revert_set(revert_set),
    .geom_r(geom_r), .queue_abort_r(queue_abort_r), .wbuf_we(wbuf_we), .wbuf_addr(wbuf_addr),
    .wbuf_data(wbuf_data)
);

// File: sim/host_model.sv
/* Host controller model that reads and writes the task-file registers.
   Assumes its tasks are called at the falling edge of clk. */
`timescale 1ns/1ps
module host_model (
    input  wire logic            clk,    // Device clock
    output ata_cmd_pkg::tf_req_t tf_req, // Register access
    input  wire logic [15:0]     rdata,  // Read data
    input  wire logic            intrq   // Host interrupt
);
    initial tf_req = '0;
    // ****************************************
    // Register access.
    // ****************************************
    task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
        tf_req.wr = w;
        tf_req.rd = !w;
        tf_req.addr = a;
        tf_req.wdata = d;
        @(negedge clk);
        q = rdata;
        tf_req.wr = 1'b0;
        tf_req.rd = 1'b0;
        // Released data lines flip so that a stale copy never passes for live data.
        tf_req.wdata = ~d;
        // One idle edge between accesses, so a strobe never changes twice in one time step.
        @(negedge clk);
    endtask : acc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [15:0] q;
        acc(1'b1, a, {8'h00, d}, q);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] q);
        acc(1'b0, a, tf_req.wdata, q);
    endtask : rd
    task automatic done(output logic [15:0] q);
        for (int i = 0; i < 1000 && intrq !== 1'b1; i++) begin
            @(negedge clk);
        end
        // A command that never ends is a mismatch of its own.
        if (intrq !== 1'b1) testbench.fails++;
        rd(3'h7, q);
    endtask : done
    // The head field is only four bits wide, so heads minus one stays within fifteen.
    task automatic geom(input logic [7:0] spt, input logic [3:0] hm1);
        wr(3'h2, spt);
        wr(3'h6, {4'ha, hm1});
        wr(3'h7, ata_cmd_pkg::OP_INIT_PARMS);
    endtask : geom
endmodule : host_model

// File: sim/testbench.sv
/* Self-checking bench for the task-file command engine.
   Assumes the engine, its package, the host model and the checker are compiled first. */
`timescale 1ns/1ps
module testbench;
    logic                 clk = 1'b0;
    logic                 rst_b, soft_rst, spindle_rot, apd_en, revert_set, wbuf_we;
    logic [31:0]          apd_limit;
    logic [7:0]           wbuf_addr;
    logic [15:0]          wbuf_data, tf_rdata_r;
    logic                 intrq_r, spin_up_r, standby_r, queue_abort_r;
    ata_cmd_pkg::tf_req_t tf_req;
    ata_cmd_pkg::geom_t   geom_r;
    int                   fails = 0;
    int                   num_checks = 0;
    int                   qa_cnt = 0;
    always #5 clk = ~clk;
    // Counted on the falling edge, away from the edge that launches the pulse.
    always @(negedge clk) if (queue_abort_r === 1'b1) qa_cnt++;
    ata_cmd_engine i_ata_cmd_engine (
        .clk(clk), .rst_b(rst_b), .soft_rst(soft_rst), .tf_req(tf_req), .tf_rdata_r(tf_rdata_r),
        .intrq_r(intrq_r), .spindle_rot(spindle_rot), .index_mark(1'b0), .spin_up_r(spin_up_r),
        .standby_r(standby_r), .apd_en(apd_en), .apd_limit(apd_limit), .revert_set(revert_set),
        .geom_r(geom_r), .queue_abort_r(queue_abort_r), .wbuf_we(wbuf_we), .wbuf_addr(wbuf_addr),
        .wbuf_data(wbuf_data)
    );
    host_model i_host_model (.clk(clk), .tf_req(tf_req), .rdata(tf_rdata_r), .intrq(intrq_r));
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] tfv(input int a, input logic [7:0] f);
        return 8'(a * 17) ^ {4'h0, f[3:0]};
    endfunction : tfv
    task automatic t_nop(input logic [7:0] f);
        logic [15:0] q;
        int n;
        n = qa_cnt;
        for (int a = 2; a < 7; a++) i_host_model.wr(3'(a), tfv(a, f));
        i_host_model.wr(3'h1, f);
        i_host_model.wr(3'h7, ata_cmd_pkg::OP_NOP);
        i_host_model.done(q);
        chk(q, 16'h0051);
        chk({15'h0, intrq_r}, 16'h0000);
        i_host_model.rd(3'h1, q);
        chk(q, 16'h0004);
        chk(16'(qa_cnt - n), {15'h0, f == 8'h00});
        for (int a = 2; a < 7; a++) begin
            i_host_model.rd(3'(a), q);
            chk(q, {8'h00, tfv(a, f)});
        end
    endtask : t_nop
    task automatic t_idle;
        logic [15:0] q;
        spindle_rot = 1'b1;
        for (int i = 0; i < 2; i++) begin
            i_host_model.wr(3'h7, i ? ata_cmd_pkg::OP_IDLE_IMM_2 : ata_cmd_pkg::OP_IDLE_IMM);
            i_host_model.done(q);
            chk(q, 16'h0050);
            chk({14'h0, standby_r, spin_up_r}, 16'h0000);
        end
        spindle_rot = 1'b0;
        i_host_model.wr(3'h7, ata_cmd_pkg::OP_IDLE_IMM);
        repeat (4) @(negedge clk);
        chk({15'h0, spin_up_r}, 16'h0001);
        spindle_rot = 1'b1;
        i_host_model.done(q);
        chk(q, 16'h0050);
    endtask : t_idle
    task automatic t_geom;
        logic [15:0] q;
        chk({4'h0, geom_r}, 16'h0000);
        i_host_model.geom(8'h00, 4'hf);
        i_host_model.done(q);
        chk({4'h0, geom_r}, 16'h000f);
        i_host_model.geom(8'h3f, 4'h3);
        i_host_model.done(q);
        chk({4'h0, geom_r}, 16'h03f3);
        soft_rst = 1'b1;
        @(negedge clk);
        soft_rst = 1'b0;
        chk({4'h0, geom_r}, 16'h0000);
        i_host_model.geom(8'h3f, 4'h3);
        i_host_model.done(q);
        revert_set = 1'b1;
        @(negedge clk);
        revert_set = 1'b0;
        chk({4'h0, geom_r}, 16'h0000);
    endtask : t_geom
    task automatic t_rbuf;
        logic [15:0] q;
        for (int i = 0; i < 256; i++) begin
            wbuf_we = 1'b1;
            wbuf_addr = 8'(i);
            wbuf_data = {8'(~i), 8'(i)};
            @(negedge clk);
        end
        wbuf_we = 1'b0;
        i_host_model.wr(3'h7, ata_cmd_pkg::OP_READ_BUF);
        repeat (2) @(negedge clk);
        i_host_model.rd(3'h7, q);
        chk(q, 16'h0058);
        for (int i = 0; i < 256; i++) begin
            i_host_model.rd(3'h0, q);
            chk(q, {8'(~i), 8'(i)});
        end
        i_host_model.done(q);
        chk(q, 16'h0050);
        i_host_model.rd(3'h0, q);
        chk(q, 16'h0000);
    endtask : t_rbuf
    task automatic t_apd;
        logic [15:0] q;
        apd_en = 1'b1;
        for (int i = 0; i < 6; i++) begin
            repeat (10) @(negedge clk);
            i_host_model.rd(3'h7, q);
        end
        chk({15'h0, standby_r}, 16'h0000);
        repeat (30) @(negedge clk);
        chk({15'h0, standby_r}, 16'h0001);
        i_host_model.wr(3'h7, ata_cmd_pkg::OP_IDLE_IMM);
        i_host_model.done(q);
        chk({15'h0, standby_r}, 16'h0000);
        repeat (30) @(negedge clk);
        chk({15'h0, standby_r}, 16'h0001);
        apd_en = 1'b0;
    endtask : t_apd
    task automatic final_report;
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        {rst_b, soft_rst, spindle_rot, apd_en, revert_set, wbuf_we} = 6'b001000;
        apd_limit = 32'h0000_0014;
        wbuf_addr = 8'h00;
        wbuf_data = 16'h0000;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        t_nop(8'h00);
        t_nop(8'h01);
        t_nop(8'hff);
        t_idle();
        t_geom();
        t_rbuf();
        t_apd();
        final_report();
    end
    // The run needs about eleven hundred cycles; ten thousand leaves ample margin.
    initial begin
        #100us;
        fails++;
        final_report();
    end
endmodule : testbench
